// [dv/host_model.sv]
// Purpose: host side of the register strobe port
// Assumes: one-cycle strobes, answer two clocks after a read
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/1ps
module host_model (
  input wire mclk,
  input wire [7:0] reg_rdata_reg,
  input wire reg_rvalid_reg,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output to);
    integer i;
    begin
      to = 1'b1;
      d = 8'h00;
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      for (i = 0; i < 4 && to; i = i + 1) begin
        @(negedge mclk);
        if (reg_rvalid_reg) begin
          d = reg_rdata_reg;
          to = 1'b0;
        end
      end
    end
  endtask
endmodule // host_model

// [dv/irq_props.sv]
// Purpose: port-level properties of the monitor interrupt block
// Assumes: config shadow follows host writes to offset 00
// Notes: bound into every instance of the block
`timescale 1ns/1ps
module irq_props (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_rvalid_reg,
  input wire conv_valid,
  input wire [1:0] addr_select_pin_low,
  input wire [1:0] addr_select_pin_high,
  input wire [6:0] slave_addr_reg,
  input wire monitor_run_reg,
  input wire int_pin_out_reg,
  input wire int_pin_oe_reg
);
  reg en_reg;
  reg clr_reg;
  reg st_reg;
  wire [1:0] lo = addr_select_pin_low[1] ? 2'h2 : addr_select_pin_low;
  wire [1:0] hi = addr_select_pin_high[1] ? 2'h2 : addr_select_pin_high;
  wire [6:0] exp_addr = 7'h10 + 7'h03 * {5'h00, hi} + {5'h00, lo};
  wire cfg_wr = reg_wr && reg_addr == 8'h00;
  // init bit restores the default config, so the shadow must follow it too
  always @(posedge mclk) begin
    if (rst || (cfg_wr && reg_wdata[7])) begin
      en_reg <= 1'b0;
      clr_reg <= 1'b1;
      st_reg <= 1'b0;
    end else if (cfg_wr) begin
      en_reg <= reg_wdata[1];
      clr_reg <= reg_wdata[3];
      st_reg <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_oe_gated_cfg: assert property (int_pin_oe_reg |-> $past(en_reg && !clr_reg))
    else $error("interrupt asserted while disabled or cleared");
  a_pin_only_low: assert property (!int_pin_out_reg)
    else $error("open-drain output value not low");
  a_clear_releases: assert property (clr_reg |=> !int_pin_oe_reg)
    else $error("clear bit did not release interrupt");
  a_clear_halts: assert property ((clr_reg || !st_reg) |=> !monitor_run_reg)
    else $error("loop running while cleared or stopped");
  a_loop_runs: assert property ((st_reg && !clr_reg) |=> monitor_run_reg)
    else $error("loop stopped while started");
  a_read_releases: assert property (reg_rd && reg_addr == 8'h01 && !$past(conv_valid)
    |-> ##2 !int_pin_oe_reg)
    else $error("status read did not release interrupt");
  a_read_answer: assert property (reg_rd |-> ##2 reg_rvalid_reg)
    else $error("read answer missing");
  a_answer_cause: assert property (reg_rvalid_reg |-> $past(reg_rd, 2))
    else $error("read answer without request");
  a_slave_addr: assert property (!$past(rst) |-> slave_addr_reg == exp_addr)
    else $error("slave address does not follow pins");
  c_status_read: cover property (reg_rd && reg_addr == 8'h01 ##2 reg_rvalid_reg);
  c_irq_drop: cover property (int_pin_oe_reg ##1 !int_pin_oe_reg);
  c_loop_start: cover property ($rose(monitor_run_reg));
endmodule // irq_props
bind monitor_interrupt_logic irq_props props_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid_reg(reg_rvalid_reg),
  .conv_valid(conv_valid), .addr_select_pin_low(addr_select_pin_low),
  .addr_select_pin_high(addr_select_pin_high), .slave_addr_reg(slave_addr_reg),
  .monitor_run_reg(monitor_run_reg), .int_pin_out_reg(int_pin_out_reg), .int_pin_oe_reg(int_pin_oe_reg));

// [dv/monitor_interrupt_logic_tb.sv]
// Purpose: self-checking bench of the monitor interrupt block
// Assumes: host_model drives registers, bench plays the sequencer
// Notes: random readings from an lfsr with a fixed start
`timescale 1ns/1ps
module monitor_interrupt_logic_tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg conv_valid = 1'b0;
  reg [2:0] conv_chan = 3'h0;
  reg [11:0] conv_data = 12'h000;
  reg [1:0] pin_lo = 2'h0;
  reg [1:0] pin_hi = 2'h0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_reg;
  wire reg_wr, reg_rd, reg_rvalid_reg, monitor_run_reg, int_pin_out_reg, int_pin_oe_reg;
  wire [6:0] slave_addr_reg;
  integer fail_count = 0;
  integer comparisons = 0;
  integer i;
  reg [31:0] seed = 32'h0000_b9a3;
  reg [7:0] d;
  reg [7:0] v;
  reg to;
  always #20 mclk = ~mclk;
  monitor_interrupt_logic dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg),
    .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data), .addr_select_pin_low(pin_lo),
    .addr_select_pin_high(pin_hi), .slave_addr_reg(slave_addr_reg), .monitor_run_reg(monitor_run_reg),
    .int_pin_out_reg(int_pin_out_reg), .int_pin_oe_reg(int_pin_oe_reg));
  host_model host_u (.mclk(mclk), .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  ////////////////////////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] lvl(input [1:0] p);
    lvl = p[1] ? 8'h02 : {6'h00, p};
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      host_u.rd(a, d, to);
      if (to) begin
        fail_count = fail_count + 1;
        give_verdict;
      end
      chk(d, e);
    end
  endtask
  // returns once the status and pin updates of this result have landed
  task conv(input [2:0] ch, input [11:0] r);
    begin
      @(negedge mclk);
      conv_valid = 1'b1;
      conv_chan = ch;
      conv_data = r;
      @(negedge mclk);
      conv_valid = 1'b0;
      conv_data = ~r;
      repeat (2) @(negedge mclk);
    end
  endtask
  task do_reset;
    begin
      @(negedge mclk);
      rst = 1'b1;
      seed = lfsr(seed);
      pin_lo = seed[1:0];
      pin_hi = seed[3:2];
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      repeat (2) @(negedge mclk);
      chk({1'b0, slave_addr_reg}, 8'h10 + 8'h03 * lvl(pin_hi) + lvl(pin_lo));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset;
    rdc(8'h00, 8'h08);
    rdc(8'h01, 8'h00);
    rdc(8'h03, 8'h00);
    rdc(8'h05, 8'h00);
    host_u.wr(8'h2E, 8'h80);
    host_u.wr(8'h2F, 8'h20);
    host_u.wr(8'h00, 8'h03);
    rdc(8'h2E, 8'h80);
    for (i = 0; i < 24; i = i + 1) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'h20 : (i == 1) ? 8'h21 : (i == 2) ? 8'h80 : (i == 3) ? 8'h81 : seed[7:0];
      conv(3'h2, {v, seed[11:8]});
      chk({7'h00, int_pin_oe_reg}, {7'h00, v > 8'h80 || v <= 8'h20});
      rdc(8'h01, (v > 8'h80 || v <= 8'h20) ? 8'h04 : 8'h00);
      chk({7'h00, int_pin_oe_reg}, 8'h00);
    end
    rdc(8'h01, 8'h00);
    host_u.wr(8'h03, 8'h04);
    conv(3'h2, 12'hFF0);
    chk({7'h00, int_pin_oe_reg}, 8'h00);
    rdc(8'h01, 8'h04);
    host_u.wr(8'h03, 8'h00);
    conv(3'h2, 12'hFF0);
    chk({7'h00, int_pin_oe_reg}, 8'h01);
    host_u.wr(8'h00, 8'h0B);
    @(negedge mclk);
    chk({6'h00, int_pin_oe_reg, monitor_run_reg}, 8'h00);
    rdc(8'h01, 8'h04);
    conv(3'h2, 12'hFF0);
    rdc(8'h01, 8'h00);
    host_u.wr(8'h00, 8'h03);
    @(negedge mclk);
    chk({7'h00, monitor_run_reg}, 8'h01);
    host_u.wr(8'h00, 8'h80);
    rdc(8'h00, 8'h08);
    host_u.wr(8'h00, 8'h03);
    host_u.wr(8'h38, 8'h19);
    host_u.wr(8'h39, 8'h14);
    conv(3'h7, 12'h032);
    rdc(8'h01, 8'h00);
    conv(3'h7, 12'h033);
    repeat (20) @(negedge mclk);
    chk({7'h00, int_pin_oe_reg}, 8'h01);
    rdc(8'h01, 8'h80);
    chk({7'h00, int_pin_oe_reg}, 8'h00);
    conv(3'h7, 12'h02A);
    chk({7'h00, int_pin_oe_reg}, 8'h01);
    rdc(8'h01, 8'h80);
    conv(3'h7, 12'h028);
    rdc(8'h01, 8'h00);
    conv(3'h7, 12'h028);
    rdc(8'h01, 8'h00);
    host_u.wr(8'h38, 8'hFF);
    conv(3'h7, 12'h1FC);
    rdc(8'h01, 8'h00);
    conv(3'h7, 12'h1FF);
    rdc(8'h01, 8'h80);
    do_reset;
    rdc(8'h00, 8'h08);
    give_verdict;
  end
endmodule // monitor_interrupt_logic_tb

// [verilog/limit_store.v]
// Purpose: 16-byte limit store with one write port and three registered read ports
// Assumes: limits are not reset, they hold whatever the host last wrote
// Notes: pair port returns the high/low limits of one channel at once
`timescale 1ns/1ps
`include "monitor_irq_map.vh"

module limit_store (
  input wire mclk,
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [2:0] pair_chan,
  input wire [3:0] host_idx,
  output reg [7:0] pair_high_reg,
  output reg [7:0] pair_low_reg,
  output reg [7:0] host_rdata_reg
);

  reg [7:0] mem [0:`LIMIT_DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    pair_high_reg <= mem[{pair_chan, 1'b0}];
    pair_low_reg <= mem[{pair_chan, 1'b1}];
    host_rdata_reg <= mem[host_idx];
  end

endmodule // limit_store

// [verilog/monitor_interrupt_logic.v]
// Purpose: window comparators, latched status, mask and open-drain interrupt output
// Assumes: conversion results arrive as one-cycle conv_valid pulses from the sequencer;
//   register accesses arrive as one-cycle reg_wr / reg_rd strobes from the serial engine
// Notes: read data appears two clocks after reg_rd, marked by reg_rvalid_reg
//
// Summary of operation
// - interrupt needs clear=0, enable=1, violation present
// - voltage violates when above high or at/below low
// - temperature above high limit raises event
// - status read returns contents then clears all
// - read-cleared status releases pin until next update
// - clear bit releases pin, status kept intact
// - clear bit held high halts monitoring loop
// - temperature event stays until read or init
// - after status read, next temperature conversion above hysteresis raises again
// - repeats stop at/below hysteresis after status read
// - nine slave addresses from two three-level pins
// - masked channel never drives the pin low
// - temperature limits are 8-bit signed whole degrees
// - temperature reading is 9-bit signed half degrees
`timescale 1ns/1ps
`include "monitor_irq_map.vh"

module monitor_interrupt_logic (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_reg,
  output reg reg_rvalid_reg,
  input wire conv_valid,
  input wire [2:0] conv_chan,
  input wire [11:0] conv_data,
  input wire [1:0] addr_select_pin_low,
  input wire [1:0] addr_select_pin_high,
  output reg [6:0] slave_addr_reg,
  output reg monitor_run_reg,
  output reg int_pin_out_reg,
  output reg int_pin_oe_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  reg start_reg;
  reg int_enable_reg;
  reg int_clear_reg;
  reg [7:0] irq_mask_reg;
  reg [7:0] irq_status_reg;
  reg temp_armed_reg;
  reg status_read_seen_reg;
  reg strap_done_reg;

  reg cmp_pending_reg;
  reg [2:0] cmp_chan_reg;
  reg [11:0] cmp_data_reg;

  reg rd_pending_reg;
  reg rd_is_limit_reg;
  reg [7:0] rd_local_reg;

  wire [7:0] pair_high;
  wire [7:0] pair_low;
  wire [7:0] host_limit;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  // the limit window ends with the two temperature limits
  wire wr_config = reg_wr && (reg_addr == `ADDR_CONTROL_CONFIG);
  wire wr_mask = reg_wr && (reg_addr == `ADDR_IRQ_MASK);
  wire in_limit = (reg_addr >= `ADDR_LIMIT_FIRST) && (reg_addr <= `ADDR_LIMIT_LAST);
  wire wr_limit = reg_wr && in_limit;
  wire rd_status = reg_rd && (reg_addr == `ADDR_IRQ_STATUS);
  wire [7:0] limit_offset = reg_addr - `ADDR_LIMIT_FIRST;
  wire [3:0] limit_idx = limit_offset[3:0];
  wire init_req = wr_config && reg_wdata[`CFG_INIT_BIT];

  limit_store u_limits (
    .mclk(mclk),
    .wr_en(wr_limit),
    .wr_idx(limit_idx),
    .wr_data(reg_wdata),
    .pair_chan(conv_chan),
    .host_idx(limit_idx),
    .pair_high_reg(pair_high),
    .pair_low_reg(pair_low),
    .host_rdata_reg(host_limit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register; reserved bits and the self-clearing init bit hold no state
  // reset image of the control register, one bit per stored field
  localparam [7:0] CFG_RESET_IMAGE = `CONTROL_CONFIG_RESET;
  localparam [0:0] START_RESET = CFG_RESET_IMAGE[`CFG_START_BIT];
  localparam [0:0] INT_ENABLE_RESET = CFG_RESET_IMAGE[`CFG_INT_ENABLE_BIT];
  localparam [0:0] INT_CLEAR_RESET = CFG_RESET_IMAGE[`CFG_INT_CLEAR_BIT];

  always @(posedge mclk) begin
    if (rst || init_req) begin
      start_reg <= START_RESET;
      int_enable_reg <= INT_ENABLE_RESET;
      int_clear_reg <= INT_CLEAR_RESET;
      irq_mask_reg <= `IRQ_MASK_RESET;
    end else begin
      if (wr_config) begin
        start_reg <= reg_wdata[`CFG_START_BIT];
        int_enable_reg <= reg_wdata[`CFG_INT_ENABLE_BIT];
        int_clear_reg <= reg_wdata[`CFG_INT_CLEAR_BIT];
      end
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion capture; limits of the channel are fetched on the same edge
  // results arriving while the clear bit is set are dropped so status stays frozen
  always @(posedge mclk) begin
    if (rst) begin
      cmp_pending_reg <= 1'b0;
      cmp_chan_reg <= 3'h0;
      cmp_data_reg <= 12'h000;
    end else begin
      cmp_pending_reg <= conv_valid && !int_clear_reg;
      if (conv_valid) begin
        cmp_chan_reg <= conv_chan;
        cmp_data_reg <= conv_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparators
  wire [7:0] volt_top = cmp_data_reg[`VOLT_CMP_MSB:`VOLT_CMP_LSB];
  wire volt_violate = (volt_top > pair_high) || (volt_top <= pair_low);

  // reading in half degrees, limits doubled to half degrees, all sign-extended to 10 bits;
  // the doubled limit keeps its own sign bit on top, otherwise a negative limit would
  // look like a large positive one and no cold threshold could ever trip
  wire [8:0] temp_raw = cmp_data_reg[`TEMP_READ_MSB:0];
  wire temp_sign = temp_raw[8];
  wire hot_sign = pair_high[7];
  wire hyst_sign = pair_low[7];
  wire signed [9:0] temp_half = {temp_sign, temp_raw};
  wire signed [9:0] hot_half = {hot_sign, pair_high, 1'b0};
  wire signed [9:0] hyst_half = {hyst_sign, pair_low, 1'b0};
  wire temp_hot = temp_half > hot_half;
  wire temp_below_hyst = temp_half <= hyst_half;

  wire is_temp = cmp_chan_reg == `TEMP_CHANNEL;
  wire temp_cmp = cmp_pending_reg && is_temp;
  wire temp_release = temp_armed_reg && temp_below_hyst && status_read_seen_reg;
  wire temp_event = temp_hot || (temp_armed_reg && !temp_release);

  reg [7:0] status_set;
  always @* begin
    status_set = `BYTE_ZERO;
    if (cmp_pending_reg) begin
      if (is_temp) begin
        status_set[`TEMP_STATUS_BIT] = temp_event;
      end else begin
        status_set[cmp_chan_reg] = volt_violate;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temperature hysteresis tracking
  // armed survives reads, so a read alone never stops the repeats
  always @(posedge mclk) begin
    if (rst || init_req) begin
      temp_armed_reg <= 1'b0;
      status_read_seen_reg <= 1'b0;
    end else begin
      if (temp_cmp) begin
        if (temp_hot) begin
          temp_armed_reg <= 1'b1;
        end else if (temp_release) begin
          temp_armed_reg <= 1'b0;
        end
      end
      // a read landing on the conversion cycle counts for the next conversion
      if (rd_status) begin
        status_read_seen_reg <= 1'b1;
      end else if (temp_cmp) begin
        status_read_seen_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status bits: an update in the read cycle survives the clear
  // the clear bit gates the pin, the loop and new results; status keeps its bits for the host
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CHANNELS; gi = gi + 1) begin : g_status
      always @(posedge mclk) begin
        if (rst || init_req) begin
          irq_status_reg[gi] <= 1'b0;
        end else begin
          irq_status_reg[gi] <= (irq_status_reg[gi] && !rd_status) || status_set[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin: open drain, only ever pulled low
  // registered so the pin never glitches while status and mask settle
  wire violation = |(irq_status_reg & ~irq_mask_reg);
  always @(posedge mclk) begin
    if (rst) begin
      int_pin_out_reg <= 1'b0;
      int_pin_oe_reg <= 1'b0;
      monitor_run_reg <= 1'b0;
    end else begin
      int_pin_out_reg <= 1'b0;
      int_pin_oe_reg <= !int_clear_reg && int_enable_reg && violation;
      monitor_run_reg <= start_reg && !int_clear_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read path; limits come from the store a clock later, so every
  // read takes two clocks to keep one latency for the serial engine
  // status is captured at the strobe edge, before that same edge clears it
  reg [7:0] local_rdata;
  always @* begin
    local_rdata = `BYTE_ZERO;
    case (reg_addr)
      `ADDR_CONTROL_CONFIG: begin
        local_rdata[`CFG_START_BIT] = start_reg;
        local_rdata[`CFG_INT_ENABLE_BIT] = int_enable_reg;
        local_rdata[`CFG_INT_CLEAR_BIT] = int_clear_reg;
      end
      `ADDR_IRQ_STATUS: begin
        local_rdata = irq_status_reg;
      end
      `ADDR_IRQ_MASK: begin
        local_rdata = irq_mask_reg;
      end
      default: begin
        local_rdata = `BYTE_ZERO;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      rd_pending_reg <= 1'b0;
      rd_is_limit_reg <= 1'b0;
      rd_local_reg <= `BYTE_ZERO;
      reg_rdata_reg <= `BYTE_ZERO;
      reg_rvalid_reg <= 1'b0;
    end else begin
      rd_pending_reg <= reg_rd;
      if (reg_rd) begin
        rd_is_limit_reg <= in_limit;
        rd_local_reg <= local_rdata;
      end
      reg_rvalid_reg <= rd_pending_reg;
      if (rd_pending_reg) begin
        reg_rdata_reg <= rd_is_limit_reg ? host_limit : rd_local_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave address straps, caught on the first edge after reset release
  // later pin movement is ignored until the next reset
  reg [6:0] lvl_low;
  reg [6:0] lvl_high;
  always @* begin
    case (addr_select_pin_low)
      `PIN_LEVEL_LOW: lvl_low = 7'h00;
      `PIN_LEVEL_MID: lvl_low = 7'h01;
      default: lvl_low = 7'h02;
    endcase
    case (addr_select_pin_high)
      `PIN_LEVEL_LOW: lvl_high = 7'h00;
      `PIN_LEVEL_MID: lvl_high = 7'h01;
      default: lvl_high = 7'h02;
    endcase
  end

  wire [13:0] high_weight = lvl_high * `PIN_LEVEL_COUNT;

  always @(posedge mclk) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      slave_addr_reg <= `SLAVE_ADDR_BASE;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      slave_addr_reg <= `SLAVE_ADDR_BASE + high_weight[6:0] + lvl_low;
    end
  end

endmodule // monitor_interrupt_logic

// [verilog/monitor_irq_map.vh]
// Purpose: register map, field positions and reset values of the monitor interrupt block
// Assumes: included by every design file of the block
// Notes: definitions only
`ifndef MONITOR_IRQ_MAP_VH
`define MONITOR_IRQ_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define ADDR_CONTROL_CONFIG 8'h00
`define ADDR_IRQ_STATUS 8'h01
`define ADDR_IRQ_MASK 8'h03
`define ADDR_LIMIT_FIRST 8'h2A
`define ADDR_LIMIT_LAST 8'h39
`define ADDR_TEMP_HIGH_LIMIT 8'h38
`define ADDR_TEMP_HYST_LIMIT 8'h39

////////////////////////////////////////////////////////////////////////////////
// control_config fields
`define CFG_START_BIT 0
`define CFG_INT_ENABLE_BIT 1
`define CFG_INT_CLEAR_BIT 3
`define CFG_INIT_BIT 7

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CONTROL_CONFIG_RESET 8'h08
`define IRQ_STATUS_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define BYTE_ZERO 8'h00

////////////////////////////////////////////////////////////////////////////////
// channels and limit store layout
`define NUM_CHANNELS 8
`define TEMP_CHANNEL 3'h7
`define TEMP_STATUS_BIT 7
`define LIMIT_DEPTH 16
`define LIMIT_IDX_W 4
// voltage reading is 12 bits, its top 8 bits meet the 8-bit limits
`define VOLT_CMP_MSB 11
`define VOLT_CMP_LSB 4
`define TEMP_READ_MSB 8

////////////////////////////////////////////////////////////////////////////////
// three-level address pins
`define PIN_LEVEL_LOW 2'h0
`define PIN_LEVEL_MID 2'h1
`define PIN_LEVEL_HIGH 2'h2
`define PIN_LEVEL_COUNT 7'h03
`define SLAVE_ADDR_BASE 7'h10

`endif
